// ==== supervisor_pkg.sv ====
// constants shared by the supply supervisor and watchdog block
package supervisor_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
  localparam int CNT_W = 24;
  localparam int HOLD_PERIOD_MS = 140;
  localparam int WD_PERIOD_MS = 1600;
  // least time rounds up; one extra tick covers the phase of the first tick
  localparam int HOLD_TICKS_DEFAULT = (HOLD_PERIOD_MS * 1000000 + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS + 1;
  localparam int WD_TICKS_DEFAULT = (WD_PERIOD_MS * 1000000) / TICK_PERIOD_NS;
  localparam int WD_DRIVE_NUM = 7;
  localparam int WD_DRIVE_DEN = 8;
  localparam int DEB_W = 8;
  localparam int DEBOUNCE_US = 10;
  localparam logic [DEB_W-1:0] DEBOUNCE_TICKS = DEB_W'((DEBOUNCE_US * 1000) / TICK_PERIOD_NS);
  localparam int IN_W = 3;
  localparam int IN_MR = 0;
  localparam int IN_KICK = 1;
  localparam int IN_SUPPLY = 2;
  // manual reset idles high (pulled up), the others idle low
  localparam logic [IN_W-1:0] IN_IDLE = 3'h1;
endpackage

// ==== cond_if.sv ====
// carrier between the input conditioner and the supervisor core
interface cond_if;
  logic tick;
  logic mr_raw_n;
  logic kick_raw;
  logic supply_raw;
  logic mr_active;
  logic kick_edge;
  logic supply_low;
  modport cond (input tick, input mr_raw_n, input kick_raw, input supply_raw,
                output mr_active, output kick_edge, output supply_low);
  modport core (output tick, output mr_raw_n, output kick_raw, output supply_raw,
                input mr_active, input kick_edge, input supply_low);
endinterface

// ==== input_conditioner.sv ====
// synchronises the three pin inputs, debounces manual reset, detects kick edges
module input_conditioner (
  input wire logic clk_sys,
  input wire logic reset_n,
  cond_if.cond io
);
  logic [supervisor_pkg::IN_W-1:0] raw;
  logic [supervisor_pkg::IN_W-1:0] s1;
  logic [supervisor_pkg::IN_W-1:0] s2;
  logic [supervisor_pkg::IN_W-1:0] s3;
  logic [supervisor_pkg::IN_W-1:0] stable;
  logic [supervisor_pkg::DEB_W-1:0] deb_cnt;
  logic mr_level;

  assign raw = {io.supply_raw, io.kick_raw, io.mr_raw_n};

  genvar i;
  generate
    for (i = 0; i < supervisor_pkg::IN_W; i++) begin : g_sync
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          s1[i] <= supervisor_pkg::IN_IDLE[i];
          s2[i] <= supervisor_pkg::IN_IDLE[i];
          s3[i] <= supervisor_pkg::IN_IDLE[i];
          stable[i] <= supervisor_pkg::IN_IDLE[i];
        end else begin
          s1[i] <= raw[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            stable[i] <= s3[i];
          end
        end
      end
    end
  endgenerate

  // level must hold for the debounce time before it is taken
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      deb_cnt <= '0;
      mr_level <= supervisor_pkg::IN_IDLE[supervisor_pkg::IN_MR];
    end else if (stable[supervisor_pkg::IN_MR] == mr_level) begin
      deb_cnt <= '0;
    end else if (deb_cnt == supervisor_pkg::DEBOUNCE_TICKS) begin
      deb_cnt <= '0;
      mr_level <= stable[supervisor_pkg::IN_MR];
    end else if (io.tick) begin
      deb_cnt <= deb_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      io.kick_edge <= 1'b0;
    end else begin
      io.kick_edge <= s3[supervisor_pkg::IN_KICK] != stable[supervisor_pkg::IN_KICK] &&
                      s2[supervisor_pkg::IN_KICK] == s3[supervisor_pkg::IN_KICK];
    end
  end

  assign io.mr_active = !mr_level;
  assign io.supply_low = stable[supervisor_pkg::IN_SUPPLY];

  property p_debounce;
    @(posedge clk_sys) disable iff (!reset_n)
    $changed(mr_level) |-> $past(deb_cnt) == supervisor_pkg::DEBOUNCE_TICKS;
  endproperty
  a_debounce: assert property (p_debounce) else $error("manual reset taken before debounce time");

  property p_kick_edge;
    @(posedge clk_sys) disable iff (!reset_n)
    (s2[supervisor_pkg::IN_KICK] == s3[supervisor_pkg::IN_KICK] &&
     s3[supervisor_pkg::IN_KICK] != stable[supervisor_pkg::IN_KICK]) |=> io.kick_edge ##1 !io.kick_edge;
  endproperty
  a_kick_edge: assert property (p_kick_edge) else $error("kick transition not seen as one edge");

  property p_mr_idle;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(reset_n) |-> !io.mr_active [*3];
  endproperty
  a_mr_idle: assert property (p_mr_idle) else $error("manual reset active right after reset");
endmodule

// ==== supply_supervisor_watchdog.sv ====
// supply supervisor: reset outputs, hold timer and watchdog
module supply_supervisor_watchdog #(
  parameter int unsigned HOLD_TICKS = supervisor_pkg::HOLD_TICKS_DEFAULT,
  parameter int unsigned WD_TICKS = supervisor_pkg::WD_TICKS_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic supply_low_in,
  input wire logic manual_reset_n_in,
  input wire logic watchdog_kick_in,
  output logic reset_n_out,
  output logic reset_out,
  output logic watchdog_kick_out,
  output logic watchdog_kick_oe
);
  localparam int CW = supervisor_pkg::CNT_W;
  localparam logic [CW-1:0] HOLD_LIMIT = CW'(HOLD_TICKS);
  localparam logic [CW-1:0] WD_LIMIT = CW'(WD_TICKS);
  localparam logic [CW-1:0] WD_DRIVE_AT = CW'((WD_TICKS * supervisor_pkg::WD_DRIVE_NUM) / supervisor_pkg::WD_DRIVE_DEN);

  cond_if cond ();

  logic [supervisor_pkg::DIV_W-1:0] div_cnt;
  logic tick;
  logic [CW-1:0] hold_cnt;
  logic [CW-1:0] wd_cnt;
  logic in_reset;
  logic next_in_reset;
  logic wd_expire;
  logic cause;

  assign cond.tick = tick;
  assign cond.mr_raw_n = manual_reset_n_in;
  assign cond.kick_raw = watchdog_kick_in;
  assign cond.supply_raw = supply_low_in;

  input_conditioner u_cond (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .io(cond.cond)
  );

  // one-cycle tick every microsecond feeds every period counter
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else if (div_cnt == supervisor_pkg::DIV_LAST) begin
      div_cnt <= '0;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  assign wd_expire = wd_cnt == WD_LIMIT;
  assign cause = cond.supply_low || cond.mr_active || wd_expire;

  always_comb begin
    next_in_reset = cause || (in_reset && hold_cnt != HOLD_LIMIT);
  end

  // hold timer restarts while any cause is present
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt <= '0;
    end else if (cause || !in_reset) begin
      hold_cnt <= '0;
    end else if (tick && hold_cnt != HOLD_LIMIT) begin
      hold_cnt <= hold_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      in_reset <= 1'b1;
      reset_out <= 1'b1;
      reset_n_out <= 1'b0;
    end else begin
      in_reset <= next_in_reset;
      reset_out <= next_in_reset;
      reset_n_out <= !next_in_reset;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wd_cnt <= '0;
    end else if (in_reset || cond.mr_active || cond.kick_edge) begin
      wd_cnt <= '0;
    end else if (tick && !wd_expire) begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end

  // weak self-drive through the series resistor; an outside driver overrides it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_kick_out <= 1'b0;
      watchdog_kick_oe <= 1'b1;
    end else begin
      watchdog_kick_out <= wd_cnt >= WD_DRIVE_AT;
      watchdog_kick_oe <= 1'b1;
    end
  end

  property p_cause_low;
    @(posedge clk_sys) disable iff (!reset_n)
    cause |=> !reset_n_out && reset_out;
  endproperty
  a_cause_low: assert property (p_cause_low) else $error("reset not asserted for a cause");

  property p_complement;
    @(posedge clk_sys) disable iff (!reset_n)
    reset_out != reset_n_out;
  endproperty
  a_complement: assert property (p_complement) else $error("reset outputs not complementary");

  property p_supply_hold;
    @(posedge clk_sys) disable iff (!reset_n)
    $fell(cond.supply_low) |=> reset_out [*8];
  endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("reset dropped right after supply recovery");

  property p_release_time;
    @(posedge clk_sys) disable iff (!reset_n)
    $fell(reset_out) |-> $past(hold_cnt) == HOLD_LIMIT && !$past(cause);
  endproperty
  a_release_time: assert property (p_release_time) else $error("reset released before hold period");

  property p_expire;
    @(posedge clk_sys) disable iff (!reset_n)
    wd_expire |=> reset_out ##1 (wd_cnt == '0 && hold_cnt == '0);
  endproperty
  a_expire: assert property (p_expire) else $error("watchdog expiry did not start reset");

  property p_kick_clears;
    @(posedge clk_sys) disable iff (!reset_n)
    cond.kick_edge |=> wd_cnt == '0;
  endproperty
  a_kick_clears: assert property (p_kick_clears) else $error("kick edge did not clear watchdog");

  property p_held_clear;
    @(posedge clk_sys) disable iff (!reset_n)
    in_reset |=> wd_cnt == '0;
  endproperty
  a_held_clear: assert property (p_held_clear) else $error("watchdog counted during reset");

  property p_restart;
    @(posedge clk_sys) disable iff (!reset_n)
    $fell(in_reset) |-> ##[1:101] (wd_cnt != '0 || cond.kick_edge || cause || in_reset);
  endproperty
  a_restart: assert property (p_restart) else $error("watchdog did not restart after release");

  property p_self_drive;
    @(posedge clk_sys) disable iff (!reset_n)
    (wd_cnt >= WD_DRIVE_AT) |=> watchdog_kick_out;
  endproperty
  a_self_drive: assert property (p_self_drive) else $error("kick not driven high in last eighth");

  property p_self_low;
    @(posedge clk_sys) disable iff (!reset_n)
    (wd_cnt < WD_DRIVE_AT) |=> !watchdog_kick_out;
  endproperty
  a_self_low: assert property (p_self_low) else $error("kick not driven low in first part");

  property p_tick_gap;
    @(posedge clk_sys) disable iff (!reset_n)
    tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick pulses closer than the divider allows");

  property p_hold_on_tick;
    @(posedge clk_sys) disable iff (!reset_n)
    $changed(hold_cnt) && hold_cnt != '0 |-> $past(tick);
  endproperty
  a_hold_on_tick: assert property (p_hold_on_tick) else $error("hold timer advanced without a tick");

  property p_wd_on_tick;
    @(posedge clk_sys) disable iff (!reset_n)
    $changed(wd_cnt) && wd_cnt != '0 |-> $past(tick);
  endproperty
  a_wd_on_tick: assert property (p_wd_on_tick) else $error("watchdog advanced without a tick");

  property p_manual_clears;
    @(posedge clk_sys) disable iff (!reset_n)
    cond.mr_active |=> wd_cnt == '0;
  endproperty
  a_manual_clears: assert property (p_manual_clears) else $error("manual reset did not clear watchdog");

  property p_restart_zero;
    @(posedge clk_sys) disable iff (!reset_n)
    $fell(in_reset) |-> wd_cnt == '0;
  endproperty
  a_restart_zero: assert property (p_restart_zero) else $error("watchdog not at zero at reset release");

  property p_hold_keeps;
    @(posedge clk_sys) disable iff (!reset_n)
    (in_reset && !cause && hold_cnt != HOLD_LIMIT) |=> in_reset;
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) else $error("reset released before hold count ended");
endmodule

// ==== kick_partner.sv ====
// processor model that services, starves or floats the watchdog kick pin
module kick_partner #(
  parameter int GAP = 4000
) (
  input wire logic clk_sys,
  input wire logic [1:0] mode,
  input wire logic watchdog_kick_out,
  input wire logic watchdog_kick_oe,
  output wire logic kick_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic drv_en = 1'b0;
  logic drv_lvl = 1'b0;
  // mode 0 floats, 1 holds low, 2 pulses low-high-low once per gap
  always @(negedge clk_sys) begin
    cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
    drv_en <= (mode != 2'h0);
    drv_lvl <= (mode == 2'h2) && (cnt < 5);
  end
  // a strong processor drive wins over the weak self-drive
  assign kick_pin = drv_en ? drv_lvl : (watchdog_kick_oe ? watchdog_kick_out : ~watchdog_kick_out);
endmodule

// ==== supply_supervisor_watchdog_tb.sv ====
// self-checking testbench of the supply supervisor and watchdog
module supply_supervisor_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HT = 20;
  localparam int WT = 80;
  localparam int HC = HT * 100;
  localparam int WC = WT * 100;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic supply_low_in = 1'b0;
  logic manual_reset_n_in = 1'b1;
  logic [1:0] mode = 2'h0;
  wire logic kick_pin;
  logic reset_n_out;
  logic reset_out;
  logic kick_out;
  logic kick_oe;
  int err_count = 0;
  int check_count = 0;
  always #5 clk_sys = ~clk_sys;
  supply_supervisor_watchdog #(.HOLD_TICKS(HT), .WD_TICKS(WT)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .supply_low_in(supply_low_in), .manual_reset_n_in(manual_reset_n_in), .watchdog_kick_in(kick_pin),
    .reset_n_out(reset_n_out), .reset_out(reset_out), .watchdog_kick_out(kick_out), .watchdog_kick_oe(kick_oe));
  kick_partner #(.GAP(WC / 2)) i_partner (.clk_sys(clk_sys), .mode(mode), .watchdog_kick_out(kick_out),
    .watchdog_kick_oe(kick_oe), .kick_pin(kick_pin));
  task summarize;
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task compare_bit(string name, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task compare_range(string name, int lo, int hi, int got);
    check_count++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  task wait_reset(logic lvl, int max);
    int n;
    n = 0;
    while (reset_out !== lvl && n < max) begin
      @(negedge clk_sys);
      n++;
    end
    compare_bit("reset_out", lvl, reset_out);
    if (reset_out !== lvl) summarize();
  endtask
  // both outputs must hold the level, complementary, every cycle
  task stay(logic lvl, int cycles);
    repeat (cycles) begin
      @(negedge clk_sys);
      if (reset_out !== lvl || reset_n_out !== ~lvl) break;
    end
    compare_bit("reset_out", lvl, reset_out);
    compare_bit("reset_n_out", ~lvl, reset_n_out);
  endtask
  task t_power_up;
    stay(1'b1, HC - 200);
    wait_reset(1'b0, 400);
  endtask
  task t_supply;
    supply_low_in = 1'b1;
    wait_reset(1'b1, 10);
    stay(1'b1, 300);
    supply_low_in = 1'b0;
    stay(1'b1, HC - 200);
    wait_reset(1'b0, 400);
  endtask
  task t_manual;
    manual_reset_n_in = 1'b0;
    repeat (500) @(negedge clk_sys);
    manual_reset_n_in = 1'b1;
    stay(1'b0, 1500);
    manual_reset_n_in = 1'b0;
    wait_reset(1'b1, 1300);
    stay(1'b1, 2000);
    manual_reset_n_in = 1'b1;
    stay(1'b1, HC);
    wait_reset(1'b0, 1500);
  endtask
  task t_kick;
    mode = 2'h2;
    stay(1'b0, 3 * WC);
    mode = 2'h1;
    wait_reset(1'b1, WC + 200);
    stay(1'b1, HC - 200);
    wait_reset(1'b0, 400);
    stay(1'b0, WC - 200);
    wait_reset(1'b1, 400);
  endtask
  task t_self;
    int n;
    mode = 2'h0;
    wait_reset(1'b0, HC + 200);
    compare_bit("watchdog_kick_oe", 1'b1, kick_oe);
    n = 0;
    while (kick_out !== 1'b1 && n < WC + 200) begin
      @(negedge clk_sys);
      n++;
    end
    compare_range("first kick_out rise", WC * 7 / 8 - 200, WC * 7 / 8 + 200, n);
    stay(1'b0, 3 * WC);
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    reset_n = 1'b1;
    t_power_up();
    t_supply();
    t_manual();
    t_kick();
    t_self();
    summarize();
  end
endmodule
